// file: verilog/osc_pkg.sv
package osc_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned AMT_W = 8;
  localparam int unsigned POS_W = 5;
  localparam logic [AMT_W-1:0] AMT_ZERO = 8'h00;
  localparam logic [AMT_W-1:0] AMT_WORD = 8'h20;
  localparam logic [AMT_W-1:0] AMT_ONE = 8'h01;
  localparam logic [WORD_W-1:0] IMM_BYTE_MAX = 32'h000000FF;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;
  localparam int unsigned MSB = 31;

  // Operand source
  typedef enum logic [1:0] {
    OSC_SRC_REG,
    OSC_SRC_IMM_SHIFTED,
    OSC_SRC_IMM_REPL
  } osc_src_type;

  // Shift kinds for a register operand
  typedef enum logic [2:0] {
    OSC_SH_NONE,
    OSC_SH_LOGIC_SHIFT_LEFT,
    OSC_SH_LOGIC_SHIFT_RIGHT,
    OSC_SH_ARITH_SHIFT_RIGHT,
    OSC_SH_ROTATE_RIGHT,
    OSC_SH_ROTATE_RIGHT_EXTEND
  } osc_shift_type;

  // Replicated byte patterns
  typedef enum logic [1:0] {
    OSC_REP_EVEN,
    OSC_REP_ODD,
    OSC_REP_ALL
  } osc_rep_type;
endpackage

// file: verilog/osc_if.sv
`timescale 1ns/1ns
// Shifter request and answer between top and core
interface osc_if;
  import osc_pkg::*;
  logic [WORD_W-1:0] src;
  osc_pkg::osc_shift_type kind;
  logic [AMT_W-1:0] amt;
  logic carry_in;
  logic [WORD_W-1:0] result;
  logic carry_out;
  logic carry_valid;
  modport req (output src, kind, amt, carry_in, input result, carry_out, carry_valid);
  modport core (input src, kind, amt, carry_in, output result, carry_out, carry_valid);
endinterface

// file: verilog/osc_shift_core.sv
`timescale 1ns/1ns
// Pure combinational barrel shifter with carry candidate
module osc_shift_core (
  osc_if.core bus
);
  import osc_pkg::*;

  // Bit picked out of the source for a given index, zero past the word
  function automatic logic pick_bit(input logic [WORD_W-1:0] v, input int idx);
    pick_bit = (idx >= 0 && idx < WORD_W) ? v[idx] : 1'b0;
  endfunction

  int n;
  logic [2*WORD_W-1:0] dbl;

  // One case per kind; lengths above the word handled explicitly
  always_comb
  begin
    n = int'(bus.amt);
    dbl = {bus.src, bus.src};
    bus.result = bus.src;
    bus.carry_out = bus.carry_in;
    bus.carry_valid = 1'b0;
    case (bus.kind)
      OSC_SH_LOGIC_SHIFT_LEFT:
      begin
        if (bus.amt != AMT_ZERO)
        begin
          bus.carry_valid = 1'b1;
          bus.result = (bus.amt >= AMT_WORD) ? WORD_ZERO : (bus.src << bus.amt);
          bus.carry_out = pick_bit(bus.src, int'(WORD_W) - n);
        end
      end
      OSC_SH_LOGIC_SHIFT_RIGHT:
      begin
        if (bus.amt != AMT_ZERO)
        begin
          bus.carry_valid = 1'b1;
          bus.result = (bus.amt >= AMT_WORD) ? WORD_ZERO : (bus.src >> bus.amt);
          bus.carry_out = pick_bit(bus.src, n - 1);
        end
      end
      OSC_SH_ARITH_SHIFT_RIGHT:
      begin
        if (bus.amt != AMT_ZERO)
        begin
          bus.carry_valid = 1'b1;
          if (bus.amt >= AMT_WORD)
          begin
            bus.result = {WORD_W{bus.src[MSB]}};
            bus.carry_out = bus.src[MSB];
          end
          else
          begin
            bus.result = WORD_W'($signed(bus.src) >>> bus.amt);
            bus.carry_out = pick_bit(bus.src, n - 1);
          end
        end
      end
      OSC_SH_ROTATE_RIGHT:
      begin
        if (bus.amt != AMT_ZERO)
        begin
          bus.carry_valid = 1'b1;
          // Low five bits give n modulo 32; zero there means a full turn
          bus.result = dbl[int'(bus.amt[POS_W-1:0]) +: WORD_W];
          bus.carry_out = bus.result[MSB];
        end
      end
      OSC_SH_ROTATE_RIGHT_EXTEND:
      begin
        bus.carry_valid = 1'b1;
        bus.result = {bus.carry_in, bus.src[WORD_W-1:1]};
        bus.carry_out = bus.src[0];
      end
      default:
      begin
        bus.result = bus.src;
      end
    endcase
  end
endmodule

// file: verilog/osc_operand_unit.sv
`timescale 1ns/1ns
module osc_operand_unit (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire osc_pkg::osc_src_type i_src_sel,
  input wire logic [osc_pkg::WORD_W-1:0] i_shift_source_register,
  input wire osc_pkg::osc_shift_type i_shift_kind,
  input wire logic [osc_pkg::AMT_W-1:0] i_shift_amount,
  input wire logic [osc_pkg::BYTE_W-1:0] i_imm_byte,
  input wire logic [osc_pkg::POS_W-1:0] i_imm_pos,
  input wire osc_pkg::osc_rep_type i_imm_rep,
  input wire logic i_carry_flag,
  input wire logic i_flag_setting,
  output logic [osc_pkg::WORD_W-1:0] o_flexible_second_operand,
  output logic o_carry_out,
  output logic o_carry_update
);
  import osc_pkg::*;

  // Replicated-byte constant for the chosen layout
  function automatic logic [WORD_W-1:0] repl(input logic [BYTE_W-1:0] b, input osc_rep_type r);
    case (r)
      OSC_REP_EVEN: repl = {8'h00, b, 8'h00, b};
      OSC_REP_ODD: repl = {b, 8'h00, b, 8'h00};
      OSC_REP_ALL: repl = {b, b, b, b};
      default: repl = WORD_ZERO;
    endcase
  endfunction

  // Byte placed at a left shift; bits pushed past the top are lost, no legal constant has any
  function automatic logic [WORD_W-1:0] imm_place(
    input logic [BYTE_W-1:0] b,
    input logic [POS_W-1:0] p
  );
    imm_place = {{(WORD_W-BYTE_W){1'b0}}, b} << p;
  endfunction

  // Only a constant that no longer fits the plain byte may move carry
  function automatic logic imm_moves_carry(input logic [WORD_W-1:0] v);
    imm_moves_carry = v > IMM_BYTE_MAX;
  endfunction

  // Shifter answers through the interface; nothing here writes the source back
  osc_if sh_bus ();

  osc_shift_core u_core (
    .bus(sh_bus)
  );

  // Registered outputs and their next values
  logic [WORD_W-1:0] operand_r;
  logic [WORD_W-1:0] operand_nxt;
  logic carry_r;
  logic carry_nxt;
  logic upd_r;
  logic upd_nxt;
  // Candidates decoded once and shared by the three groups
  logic [WORD_W-1:0] imm_val;
  logic [WORD_W-1:0] repl_val;
  logic imm_carry_hit;
  logic reg_carry_hit;

  // Feed the shifter; it never writes the source back
  assign sh_bus.src = i_shift_source_register;
  assign sh_bus.kind = i_shift_kind;
  assign sh_bus.amt = i_shift_amount;
  assign sh_bus.carry_in = i_carry_flag;

  // Constants and carry conditions, all within one cycle
  always_comb
  begin
    imm_val = imm_place(i_imm_byte, i_imm_pos);
    repl_val = repl(i_imm_byte, i_imm_rep);
    imm_carry_hit = i_flag_setting && imm_moves_carry(imm_val);
    reg_carry_hit = i_flag_setting && sh_bus.carry_valid;
  end

  // Operand group: pick the constant or the shifted register
  always_comb
  begin
    operand_nxt = sh_bus.result;
    case (i_src_sel)
      OSC_SRC_IMM_SHIFTED:
      begin
        operand_nxt = imm_val;
      end
      OSC_SRC_IMM_REPL:
      begin
        operand_nxt = repl_val;
      end
      OSC_SRC_REG:
      begin
        operand_nxt = sh_bus.result;
      end
      default:
      begin
        operand_nxt = sh_bus.result;
      end
    endcase
  end

  // Operand register; zero after reset keeps the consuming stage quiet
  // Registering costs one cycle of latency; the consumer reads the operand one edge later
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      operand_r <= WORD_ZERO;
    end
    else
    begin
      operand_r <= operand_nxt;
    end
  end

  // Carry group: the flag's present value unless a source earns the update
  always_comb
  begin
    carry_nxt = i_carry_flag;
    case (i_src_sel)
      OSC_SRC_IMM_SHIFTED:
      begin
        if (imm_carry_hit)
        begin
          carry_nxt = imm_val[MSB];
        end
      end
      OSC_SRC_IMM_REPL:
      begin
        carry_nxt = i_carry_flag; // Carry untouched
      end
      OSC_SRC_REG:
      begin
        if (reg_carry_hit)
        begin
          carry_nxt = sh_bus.carry_out;
        end
      end
      default:
      begin
        carry_nxt = i_carry_flag;
      end
    endcase
  end

  // Carry register
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      carry_r <= 1'b0;
    end
    else
    begin
      carry_r <= carry_nxt;
    end
  end

  // Update group: kept apart from the carry value so the flag stage
  // can tell a rewrite with the same value from a plain hold
  always_comb
  begin
    upd_nxt = 1'b0;
    case (i_src_sel)
      OSC_SRC_IMM_SHIFTED:
      begin
        upd_nxt = imm_carry_hit;
      end
      OSC_SRC_IMM_REPL:
      begin
        upd_nxt = 1'b0;
      end
      OSC_SRC_REG:
      begin
        upd_nxt = reg_carry_hit;
      end
      default:
      begin
        upd_nxt = 1'b0;
      end
    endcase
  end

  // Update register; low after reset so no stray flag write follows it
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      upd_r <= 1'b0;
    end
    else
    begin
      upd_r <= upd_nxt;
    end
  end

  // Ports come straight from the three registers
  assign o_flexible_second_operand = operand_r;
  assign o_carry_out = carry_r;
  assign o_carry_update = upd_r;
endmodule

// file: verification/osc_operand_unit_assertions.sv
`timescale 1ns/1ns
// Port checks; each ties a registered output to the inputs of the cycle before
module osc_operand_unit_checker
  import osc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire osc_pkg::osc_src_type i_src_sel,
  input wire logic [osc_pkg::WORD_W-1:0] i_shift_source_register,
  input wire osc_pkg::osc_shift_type i_shift_kind,
  input wire logic [osc_pkg::AMT_W-1:0] i_shift_amount,
  input wire logic [osc_pkg::BYTE_W-1:0] i_imm_byte,
  input wire logic [osc_pkg::POS_W-1:0] i_imm_pos,
  input wire osc_pkg::osc_rep_type i_imm_rep,
  input wire logic i_carry_flag,
  input wire logic i_flag_setting,
  input wire logic [osc_pkg::WORD_W-1:0] o_flexible_second_operand,
  input wire logic o_carry_out,
  input wire logic o_carry_update
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Register source select, shared by most checks
  wire logic rs = i_src_sel == OSC_SRC_REG;
  pass_through_a: assert property (rs && i_shift_kind == OSC_SH_NONE |=>
    o_flexible_second_operand == $past(i_shift_source_register) && !o_carry_update)
    else $error("pass through altered");
  zero_length_a: assert property (rs && i_shift_kind != OSC_SH_ROTATE_RIGHT_EXTEND
    && i_shift_amount == AMT_ZERO |=> !o_carry_update && o_carry_out == $past(i_carry_flag))
    else $error("zero length touched carry");
  right_long_zero_a: assert property (rs && i_shift_kind == OSC_SH_LOGIC_SHIFT_RIGHT
    && i_shift_amount >= AMT_WORD |=> o_flexible_second_operand == WORD_ZERO)
    else $error("long right shift not zero");
  arith_long_sign_a: assert property (rs && i_shift_kind == OSC_SH_ARITH_SHIFT_RIGHT
    && i_shift_amount >= AMT_WORD |=> o_flexible_second_operand == {32{$past(
    i_shift_source_register[31])}} && o_carry_out == $past(i_shift_source_register[31]))
    else $error("long arith shift not sign");
  extend_fill_a: assert property (rs && i_shift_kind == OSC_SH_ROTATE_RIGHT_EXTEND |=>
    o_flexible_second_operand == {$past(i_carry_flag), $past(i_shift_source_register[31:1])})
    else $error("extended rotate wrong");
  repl_carry_a: assert property (i_src_sel == OSC_SRC_IMM_REPL |=> !o_carry_update)
    else $error("replicated constant set carry");
  no_flag_a: assert property (!i_flag_setting |=> !o_carry_update)
    else $error("carry update without flag setting");
  imm_place_a: assert property (i_src_sel == OSC_SRC_IMM_SHIFTED |=>
    o_flexible_second_operand == ({24'h000000, $past(i_imm_byte)} << $past(i_imm_pos)))
    else $error("shifted constant misplaced");
  cover property (i_src_sel == OSC_SRC_IMM_SHIFTED ##1 o_carry_update);
  cover property (rs && i_shift_kind == OSC_SH_ROTATE_RIGHT ##1 o_carry_update);
  cover property (rs && i_shift_kind == OSC_SH_ROTATE_RIGHT_EXTEND ##1 o_carry_update);
endmodule

// file: verification/osc_flag_model.sv
`timescale 1ns/1ns
// Carry flag of the consuming stage, written only when the unit asks
module osc_flag_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_carry_out,
  input wire logic i_carry_update,
  output logic o_carry_flag
);
  logic flag_r;
  logic flag_nxt;
  // Hold unless an update is flagged
  always_comb flag_nxt = i_carry_update ? i_carry_out : flag_r;
  // No branch target passes here; program-counter bit 0 stays with software
  always_ff @(posedge i_mclk) flag_r <= i_srst ? 1'h0 : flag_nxt;
  assign o_carry_flag = flag_r;
endmodule

// file: verification/osc_operand_unit_tb.sv
`timescale 1ns/1ns
module osc_operand_unit_tb;
  import osc_pkg::*;
  typedef struct packed {osc_shift_type k; logic [7:0] n; logic [31:0] s; logic c;
    logic u; logic y; logic [31:0] r;} osc_row_type;
  logic i_mclk = 1'h0;
  logic i_srst = 1'h1;
  osc_src_type sel = OSC_SRC_REG;
  osc_shift_type kind = OSC_SH_NONE;
  osc_rep_type rep = OSC_REP_ALL;
  logic [31:0] src = 32'h0;
  logic [7:0] amt = 8'h00;
  logic [7:0] byt = 8'h00;
  logic [4:0] pos = 5'h00;
  logic cf = 1'h0;
  logic fs = 1'h1;
  logic use_flag = 1'h0;
  wire logic [31:0] res;
  wire logic cy;
  wire logic upd;
  wire logic flag;
  int mismatches = 0;
  int compares = 0;
  // Register shift cases: kind, length, source, carry in, update, carry, result
  osc_row_type rows [14] = '{
    '{OSC_SH_LOGIC_SHIFT_LEFT,8'h01,32'h80000001,1'h0,1'h1,1'h1,32'h00000002},
    '{OSC_SH_LOGIC_SHIFT_LEFT,8'h20,32'h00000001,1'h0,1'h1,1'h1,32'h00000000},
    '{OSC_SH_LOGIC_SHIFT_LEFT,8'h21,32'hFFFFFFFF,1'h1,1'h1,1'h0,32'h00000000},
    '{OSC_SH_LOGIC_SHIFT_RIGHT,8'h20,32'h80000000,1'h0,1'h1,1'h1,32'h00000000},
    '{OSC_SH_ARITH_SHIFT_RIGHT,8'h04,32'h80000018,1'h0,1'h1,1'h1,32'hF8000001},
    '{OSC_SH_ARITH_SHIFT_RIGHT,8'h28,32'h80000000,1'h0,1'h1,1'h1,32'hFFFFFFFF},
    '{OSC_SH_ROTATE_RIGHT,8'h04,32'h0000001F,1'h0,1'h1,1'h1,32'hF0000001},
    '{OSC_SH_ROTATE_RIGHT,8'h20,32'h80000001,1'h0,1'h1,1'h1,32'h80000001},
    '{OSC_SH_ROTATE_RIGHT,8'h24,32'h0000001F,1'h0,1'h1,1'h1,32'hF0000001},
    '{OSC_SH_ROTATE_RIGHT_EXTEND,8'h00,32'h00000001,1'h1,1'h1,1'h1,32'h80000000},
    '{OSC_SH_LOGIC_SHIFT_RIGHT,8'h01,32'h00000003,1'h0,1'h1,1'h1,32'h00000001},
    '{OSC_SH_LOGIC_SHIFT_RIGHT,8'h21,32'hFFFFFFFF,1'h1,1'h1,1'h0,32'h00000000},
    '{OSC_SH_LOGIC_SHIFT_LEFT,8'h00,32'hA5A5A5A5,1'h1,1'h0,1'h1,32'hA5A5A5A5},
    '{OSC_SH_NONE,8'h05,32'h12345678,1'h1,1'h0,1'h1,32'h12345678}};
  always #5 i_mclk = ~i_mclk;
  osc_operand_unit DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_src_sel(sel),
    .i_shift_source_register(src), .i_shift_kind(kind), .i_shift_amount(amt),
    .i_imm_byte(byt), .i_imm_pos(pos), .i_imm_rep(rep), .i_carry_flag(use_flag ? flag : cf),
    .i_flag_setting(fs), .o_flexible_second_operand(res), .o_carry_out(cy),
    .o_carry_update(upd));
  osc_flag_model flags (.i_mclk(i_mclk), .i_srst(i_srst), .i_carry_out(cy),
    .i_carry_update(upd), .o_carry_flag(flag));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Outputs show one edge after the inputs are taken
  task automatic step;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence: table first, then constants, flag feedback and reset
  initial
  begin
    repeat (20) @(posedge i_mclk);
    #1 i_srst = 1'h0;
    foreach (rows[i])
    begin
      kind = rows[i].k;
      amt = rows[i].n;
      src = rows[i].s;
      cf = rows[i].c;
      step;
      chk({upd, cy, res}, {rows[i].u, rows[i].y, rows[i].r});
    end
    sel = OSC_SRC_IMM_SHIFTED;
    byt = 8'hA5;
    pos = 5'h18;
    step;
    chk({upd, cy, res}, {2'h3, 32'hA5000000});
    byt = 8'hFF;
    pos = 5'h00;
    cf = 1'h1;
    step;
    chk({upd, cy, res}, {2'h1, 32'h000000FF});
    sel = OSC_SRC_IMM_REPL;
    byt = 8'h3C;
    rep = OSC_REP_EVEN;
    step;
    chk(res, 34'h0003C003C);
    rep = OSC_REP_ODD;
    step;
    chk(res, 34'h03C003C00);
    rep = OSC_REP_ALL;
    step;
    chk({upd, cy, res}, {2'h1, 32'h3C3C3C3C});
    sel = OSC_SRC_REG;
    kind = OSC_SH_LOGIC_SHIFT_LEFT;
    amt = 8'h01;
    src = 32'h80000000;
    cf = 1'h0;
    fs = 1'h0;
    step;
    chk({upd, cy, res}, 34'h0);
    kind = OSC_SH_ROTATE_RIGHT_EXTEND;
    src = 32'h00000002;
    fs = 1'h1;
    use_flag = 1'h1;
    step;
    chk({upd, cy, res}, {2'h2, 32'h80000001});
    src = 32'h00000000;
    step;
    step;
    chk({upd, cy, res}, 34'h200000000);
    i_srst = 1'h1;
    step;
    chk({upd, cy, res}, 34'h0);
    i_srst = 1'h0;
    step;
    chk({upd, cy, res}, 34'h200000000);
    report_and_stop;
  end
  // Hang guard, far beyond the few dozen cycles the sequence needs
  initial
  begin
    repeat (2000) @(posedge i_mclk);
    mismatches++;
    report_and_stop;
  end
endmodule
bind osc_operand_unit osc_operand_unit_checker chk_i (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_src_sel(i_src_sel), .i_shift_source_register(i_shift_source_register),
  .i_shift_kind(i_shift_kind), .i_shift_amount(i_shift_amount), .i_imm_byte(i_imm_byte),
  .i_imm_pos(i_imm_pos), .i_imm_rep(i_imm_rep), .i_carry_flag(i_carry_flag),
  .i_flag_setting(i_flag_setting), .o_flexible_second_operand(o_flexible_second_operand),
  .o_carry_out(o_carry_out), .o_carry_update(o_carry_update));
